// file: design/adc_frame_pkg.sv
// Shared constants and carrier types for the converter frame and alarm logic.
// Assumes an 18-bit converter core on the system clock and a serial host
// that times every transfer on falling serial-clock edges.
`default_nettype none

package adc_frame_pkg;

  // ---------------------------------------------------------------------
  // Code format
  // ---------------------------------------------------------------------
  localparam int                CODE_W     = 18;
  localparam int                CODE_STEPS = 262144;
  localparam logic [CODE_W-1:0] CODE_RST   = 18'h0_0000;
  localparam real               REF_V      = 4.096;
  localparam real               LSB_WIDE_UV = 78.125;
  localparam real               LSB_MID_UV  = 39.0625;
  localparam real               LSB_NARROW_UV = 19.53125;

  // Signed width that holds threshold +/- hysteresis +/- small offsets
  localparam int                LIM_W      = CODE_W + 2;
  localparam logic [LIM_W-1:0]  LIM_ONE    = 20'h0_0001;
  localparam logic [LIM_W-1:0]  LIM_TWO    = 20'h0_0002;

  // ---------------------------------------------------------------------
  // Serial frame timing, counted in falling serial-clock edges
  // ---------------------------------------------------------------------
  localparam int                CFG_W      = 16;
  localparam int                CNT_W      = 6;
  localparam logic [CNT_W-1:0]  CNT_RST    = 6'h00;
  localparam logic [CNT_W-1:0]  CNT_ONE    = 6'h01;
  localparam logic [CNT_W-1:0]  CNT_MAX    = 6'h3F;
  // Count value just before the 16th edge
  localparam logic [CNT_W-1:0]  CNT_EDGE16 = 6'h0F;
  // Count value once the last result bit has been on SDO for an edge
  localparam logic [CNT_W-1:0]  CNT_TAIL   = 6'h22;
  localparam logic [CFG_W-1:0]  CFG_RST    = 16'h0000;

  // ---------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [CODE_W-1:0] hi_thr;
    logic [CODE_W-1:0] hi_hys;
    logic [CODE_W-1:0] lo_thr;
    logic [CODE_W-1:0] lo_hys;
  } alarm_limits_t;

  // State of the logic clocked by the serial clock
  typedef struct packed {
    logic [CNT_W-1:0]  cnt;
    logic [CFG_W-1:0]  cfg_sh;
    logic [CODE_W-1:0] out_sh;
    logic              sdo;
    logic              done;
    logic              rdy_s1;
    logic              rdy_s2;
  } link_state_t;

  localparam link_state_t LINK_RST = '{
    cnt: CNT_RST, cfg_sh: CFG_RST, out_sh: CODE_RST,
    sdo: 1'b0, done: 1'b0, rdy_s1: 1'b0, rdy_s2: 1'b0};

endpackage : adc_frame_pkg

`default_nettype wire

// file: design/adc_serial_frame_alarm.sv
// Serial frame port and per-channel hysteresis alarms of a sampling converter.
// Assumes a converter core on mclk (conv_start / conv_done / conv_code) and a
// host that drives cs_n, sclk and sdi; the SDO pad is resolved outside.
`default_nettype none

// What this block does
// - Results leave as unsigned straight binary
// - Every result is one 18-bit code
// - Step sizes follow range with 4.096 V
// - Alarm output changes only at 16th edge
// - Alarm high when any channel has tripped
// - Own high/low threshold and hysteresis per channel
// - High alarm sets above threshold plus hysteresis
// - High alarm clears at threshold minus hysteresis minus 2
// - Low alarm sets below threshold minus hysteresis minus 1
// - Low alarm clears at threshold plus hysteresis plus 1
// - Active flag follows the current alarm state
// - Tripped flag latches until flags are read
// - Chip-select fall samples channel, starts conversion
// - Converted channel was chosen in previous frame
// - Serial transfers use falling clock edges only
// - First 16 falling edges capture the config word
// - New config applies at next chip-select fall
// - SDO driven only while chip select low
// - SDO low through first 15 falling edges
// - MSB at 16th edge, then one per edge
// - SDO low after last bit until deselect
// - Chip select high means idle, no frame
module adc_serial_frame_alarm
  import adc_frame_pkg::*;
#(
  parameter int NCH = 8
)(
  input  wire logic                     mclk,        // System clock
  input  wire logic                     reset_n,     // Sync reset, low
  input  wire logic                     sclk,        // Serial clock pin
  input  wire logic                     cs_n,        // Chip select pin
  input  wire logic                     sdi,         // Serial data in
  output var  logic                     sdo_out,     // Serial data out
  output var  logic                     sdo_oe,      // SDO drive enable
  output var  logic                     alarm,       // Alarm pin, high
  output var  logic                     conv_start,  // Start pulse to core
  output var  logic [$clog2(NCH)-1:0]   conv_ch,     // Channel to sample
  input  wire logic                     conv_done,   // Core result strobe
  input  wire logic [CODE_W-1:0]        conv_code,   // Core result code
  input  wire alarm_limits_t [NCH-1:0]  limits,      // Per-channel limits
  input  wire logic                     flag_rd,     // Alarm flags read
  output var  logic [NCH-1:0]           active_hi,   // High alarm active
  output var  logic [NCH-1:0]           active_lo,   // Low alarm active
  output var  logic [NCH-1:0]           tripped_hi,  // High alarm latched
  output var  logic [NCH-1:0]           tripped_lo,  // Low alarm latched
  output var  logic [CODE_W-1:0]        result_code  // Last result
);

  localparam int CH_W = $clog2(NCH);

  // Refuse channel counts that the select field cannot serve
  if (NCH < 2 || NCH > 16 || CH_W > CFG_W)
  begin : g_bad_nch
    $error("adc_serial_frame_alarm: NCH must be 2 to 16");
  end

  // One code step is the span over CODE_STEPS, so the code must fill it
  if (CODE_STEPS != (1 << CODE_W))
  begin : g_bad_code
    $error("adc_serial_frame_alarm: code width and step count differ");
  end

  // ---------------------------------------------------------------------
  // Core state on mclk
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic              cs_s1;
    logic              cs_s2;
    logic              cs_s3;
    logic              dn_s1;
    logic              dn_s2;
    logic              dn_s3;
    logic [CH_W-1:0]   ch_pend;
    logic [CH_W-1:0]   ch_cur;
    logic [CH_W-1:0]   conv_ch;
    logic              conv_start;
    logic [CODE_W-1:0] result;
    logic              res_valid;
    logic [NCH-1:0]    act_hi;
    logic [NCH-1:0]    act_lo;
    logic [NCH-1:0]    trip_hi;
    logic [NCH-1:0]    trip_lo;
    logic              alarm;
    logic              sdo_oe;
  } core_state_t;

  localparam core_state_t CORE_RST = '{
    cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1,
    dn_s1: 1'b0, dn_s2: 1'b0, dn_s3: 1'b0,
    ch_pend: '0, ch_cur: '0, conv_ch: '0, conv_start: 1'b0,
    result: CODE_RST, res_valid: 1'b0,
    act_hi: '0, act_lo: '0, trip_hi: '0, trip_lo: '0,
    alarm: 1'b0, sdo_oe: 1'b0};

  core_state_t core_reg;
  core_state_t core_next;
  link_state_t lnk_reg;
  link_state_t lnk_next;

  logic           cs_fall;
  logic           cs_rise;
  logic           done_rise;
  logic [NCH-1:0] hi_set_c;
  logic [NCH-1:0] hi_clr_c;
  logic [NCH-1:0] lo_set_c;
  logic [NCH-1:0] lo_clr_c;
  logic [NCH-1:0] sel_c;

  // ---------------------------------------------------------------------
  // Per-channel limit comparators
  // ---------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_cmp
      logic signed [LIM_W-1:0] code_x;
      logic signed [LIM_W-1:0] ht;
      logic signed [LIM_W-1:0] hh;
      logic signed [LIM_W-1:0] lt;
      logic signed [LIM_W-1:0] lh;
      assign code_x = signed'({2'b00, conv_code});
      assign ht     = signed'({2'b00, limits[gi].hi_thr});
      assign hh     = signed'({2'b00, limits[gi].hi_hys});
      assign lt     = signed'({2'b00, limits[gi].lo_thr});
      assign lh     = signed'({2'b00, limits[gi].lo_hys});
      assign hi_set_c[gi] = code_x > (ht + hh);
      assign hi_clr_c[gi] =
        code_x <= (ht - hh - signed'(LIM_TWO));
      assign lo_set_c[gi] =
        code_x < (lt - lh - signed'(LIM_ONE));
      assign lo_clr_c[gi] =
        code_x >= (lt + lh + signed'(LIM_ONE));
      assign sel_c[gi] = conv_done && (core_reg.conv_ch == CH_W'(gi));
    end
  endgenerate

  assign cs_fall   = core_reg.cs_s3 && !core_reg.cs_s2;
  assign cs_rise   = !core_reg.cs_s3 && core_reg.cs_s2;
  assign done_rise = core_reg.dn_s2 && !core_reg.dn_s3;

  // ---------------------------------------------------------------------
  // Core next state
  // ---------------------------------------------------------------------
  always_comb
  begin
    logic [NCH-1:0] hi_n;
    logic [NCH-1:0] lo_n;
    hi_n = '0;
    lo_n = '0;
    core_next = core_reg;
    core_next.cs_s1 = cs_n;
    core_next.cs_s2 = core_reg.cs_s1;
    core_next.cs_s3 = core_reg.cs_s2;
    core_next.dn_s1 = lnk_reg.done;
    core_next.dn_s2 = core_reg.dn_s1;
    core_next.dn_s3 = core_reg.dn_s2;
    core_next.conv_start = 1'b0;
    core_next.sdo_oe = !core_reg.cs_s2;

    // New frame: sample the channel chosen last frame
    if (cs_fall)
    begin
      core_next.conv_start = 1'b1;
      core_next.conv_ch    = core_reg.ch_pend;
      core_next.ch_cur     = core_reg.ch_pend;
      core_next.res_valid  = 1'b0;
    end

    // Result and alarm update for the channel just converted
    hi_n = (core_reg.act_hi & ~(sel_c & hi_clr_c)) | (sel_c & hi_set_c);
    lo_n = (core_reg.act_lo & ~(sel_c & lo_clr_c)) | (sel_c & lo_set_c);
    if (conv_done)
    begin
      core_next.result    = conv_code;
      core_next.res_valid = 1'b1;
    end
    core_next.act_hi = hi_n;
    core_next.act_lo = lo_n;

    // Latched flags: a new trip wins over a read in the same cycle
    core_next.trip_hi = (core_reg.trip_hi & ~{NCH{flag_rd}})
                        | (sel_c & hi_set_c);
    core_next.trip_lo = (core_reg.trip_lo & ~{NCH{flag_rd}})
                        | (sel_c & lo_set_c);

    // 16th edge seen: update alarm pin, take the new configuration word
    if (done_rise)
    begin
      core_next.alarm = |{core_reg.trip_hi, core_reg.trip_lo};
      if (lnk_reg.cfg_sh[CH_W-1:0] < CH_W'(NCH - 1) ||
          lnk_reg.cfg_sh[CH_W-1:0] == CH_W'(NCH - 1))
        core_next.ch_pend = lnk_reg.cfg_sh[CH_W-1:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      core_reg <= CORE_RST;
    else
      core_reg <= core_next;
  end

  // ---------------------------------------------------------------------
  // Link logic on falling serial-clock edges
  // ---------------------------------------------------------------------
  always_comb
  begin
    lnk_next = lnk_reg;
    lnk_next.rdy_s1 = core_reg.res_valid;
    lnk_next.rdy_s2 = lnk_reg.rdy_s1;
    if (lnk_reg.cnt != CNT_MAX)
      lnk_next.cnt = lnk_reg.cnt + CNT_ONE;
    if (lnk_reg.cnt < CNT_EDGE16 || lnk_reg.cnt == CNT_EDGE16)
      lnk_next.cfg_sh = {lnk_reg.cfg_sh[CFG_W-2:0], sdi};
    if (lnk_reg.cnt == CNT_EDGE16)
    begin
      lnk_next.done   = 1'b1;
      lnk_next.sdo    = core_reg.result[CODE_W-1];
      lnk_next.out_sh = {core_reg.result[CODE_W-2:0], 1'b0};
    end
    else if (lnk_reg.cnt > CNT_EDGE16)
    begin
      lnk_next.sdo    = lnk_reg.out_sh[CODE_W-1];
      lnk_next.out_sh = {lnk_reg.out_sh[CODE_W-2:0], 1'b0};
    end
    else
      lnk_next.sdo = 1'b0;
  end

  // Deselect ends the frame even though the serial clock stands still
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
      lnk_reg <= LINK_RST;
    else
      lnk_reg <= lnk_next;
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign sdo_out     = lnk_reg.sdo;
  assign sdo_oe      = core_reg.sdo_oe;
  assign alarm       = core_reg.alarm;
  assign conv_start  = core_reg.conv_start;
  assign conv_ch     = core_reg.conv_ch;
  assign active_hi   = core_reg.act_hi;
  assign active_lo   = core_reg.act_lo;
  assign tripped_hi  = core_reg.trip_hi;
  assign tripped_lo  = core_reg.trip_lo;
  assign result_code = core_reg.result;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  property p_alarm_moment;
    @(posedge mclk) disable iff (!reset_n)
      (core_reg.alarm != $past(core_reg.alarm)) |-> $past(done_rise, 1);
  endproperty
  a_alarm_moment: assert property (p_alarm_moment)
    else $error("alarm changed outside the 16th-edge update");

  property p_alarm_level;
    @(posedge mclk) disable iff (!reset_n)
      done_rise |=> core_reg.alarm ==
        $past(|{core_reg.trip_hi, core_reg.trip_lo});
  endproperty
  a_alarm_level: assert property (p_alarm_level)
    else $error("alarm level does not match tripped flags");

  property p_hi_set;
    @(posedge mclk) disable iff (!reset_n)
      (conv_done && |(sel_c & hi_set_c)) |=> |(core_reg.act_hi
        & $past(sel_c)) && |(core_reg.trip_hi & $past(sel_c));
  endproperty
  a_hi_set: assert property (p_hi_set)
    else $error("high alarm not set above upper limit");

  property p_hi_clr;
    @(posedge mclk) disable iff (!reset_n)
      (conv_done && |(sel_c & hi_clr_c)) |=>
        !(|(core_reg.act_hi & $past(sel_c)));
  endproperty
  a_hi_clr: assert property (p_hi_clr)
    else $error("high alarm not cleared at lower limit");

  property p_lo_set;
    @(posedge mclk) disable iff (!reset_n)
      (conv_done && |(sel_c & lo_set_c)) |=>
        |(core_reg.act_lo & $past(sel_c));
  endproperty
  a_lo_set: assert property (p_lo_set)
    else $error("low alarm not set below lower limit");

  property p_lo_clr;
    @(posedge mclk) disable iff (!reset_n)
      (conv_done && |(sel_c & lo_clr_c)) |=>
        !(|(core_reg.act_lo & $past(sel_c)));
  endproperty
  a_lo_clr: assert property (p_lo_clr)
    else $error("low alarm not cleared at upper limit");

  property p_trip_hold;
    @(posedge mclk) disable iff (!reset_n)
      !flag_rd |=> (core_reg.trip_hi & $past(core_reg.trip_hi))
        == $past(core_reg.trip_hi);
  endproperty
  a_trip_hold: assert property (p_trip_hold)
    else $error("tripped flag dropped without a read");

  property p_frame_channel;
    @(posedge mclk) disable iff (!reset_n)
      cs_fall |=> core_reg.conv_start && core_reg.conv_ch ==
        $past(core_reg.ch_pend) && core_reg.ch_cur == $past(core_reg.ch_pend);
  endproperty
  a_frame_channel: assert property (p_frame_channel)
    else $error("frame did not convert the earlier chosen channel");

  property p_oe_follows_cs;
    @(posedge mclk) disable iff (!reset_n)
      $fell(core_reg.cs_s2) |=> core_reg.sdo_oe [*2];
  endproperty
  a_oe_follows_cs: assert property (p_oe_follows_cs)
    else $error("SDO not driven after chip select fell");

  property p_sdo_early_low;
    @(negedge sclk) disable iff (cs_n)
      (lnk_reg.cnt < CNT_EDGE16) |-> !lnk_reg.sdo;
  endproperty
  a_sdo_early_low: assert property (p_sdo_early_low)
    else $error("SDO not low during first 15 edges");

  property p_sdo_msb;
    @(negedge sclk) disable iff (cs_n)
      (lnk_reg.cnt == CNT_EDGE16) |=>
        lnk_reg.sdo == $past(core_reg.result[CODE_W-1]) && lnk_reg.done;
  endproperty
  a_sdo_msb: assert property (p_sdo_msb)
    else $error("MSB not launched on 16th edge");

  property p_sdo_tail;
    @(negedge sclk) disable iff (cs_n)
      (lnk_reg.cnt >= CNT_TAIL) |-> !lnk_reg.sdo;
  endproperty
  a_sdo_tail: assert property (p_sdo_tail)
    else $error("SDO not low after the last result bit");

  property p_result_ready;
    @(negedge sclk) disable iff (cs_n)
      (lnk_reg.cnt == CNT_EDGE16) |-> lnk_reg.rdy_s2;
  endproperty
  a_result_ready: assert property (p_result_ready)
    else $error("result launched before the conversion had finished");

  c_frame:   cover property (@(posedge mclk) disable iff (!reset_n)
    cs_fall ##[1:200] conv_done);
  c_alarm:   cover property (@(posedge mclk) disable iff (!reset_n)
    $rose(core_reg.alarm));
  c_rd_clr:  cover property (@(posedge mclk) disable iff (!reset_n)
    flag_rd && |core_reg.trip_lo);
  c_tail:    cover property (@(negedge sclk) disable iff (cs_n)
    lnk_reg.cnt == CNT_TAIL);

endmodule : adc_serial_frame_alarm

`default_nettype wire

// file: test/host_model.sv
// Serial host model: frames cs_n, sclk and sdi and collects the result.
// Assumes the bench calls frame() and feeds back the resolved SDO line.
`default_nettype none

module host_model
(
  output var  logic cs_n,    // Chip select, low
  output var  logic sclk,    // Serial clock, idle high
  output var  logic sdi,     // Serial data to device
  input  wire logic sdo,     // Resolved SDO line
  input  wire logic sdo_oe,  // Device SDO enable
  input  wire logic alarm    // Device alarm pin
);
  timeunit 1ns;
  timeprecision 100ps;

  // Short low at start gives the link's asynchronous clear a rising edge
  initial
  begin
    cs_n = 1'b0;
    sclk = 1'b1;
    sdi  = 1'b0;
    #1;
    cs_n = 1'b1;
  end

  // ---------------------------------------------------------------
  // One 36-edge frame at 125 ns per bit; clock stands still outside
  // ---------------------------------------------------------------
  task automatic frame(input  logic [15:0] w,
                       output logic [17:0] r,
                       output logic        bad,
                       output logic        a15);
    int i;
    r    = 18'h0_0000;
    bad  = 1'b0;
    a15  = 1'b0;
    cs_n = 1'b0;
    #200;
    if (sdo_oe !== 1'b1) bad = 1'b1;
    // 16th edge lands long after the core has answered
    for (i = 1; i <= 36; i++)
    begin
      sdi = (i <= 16) ? w[16-i] : ~sdi;
      #62.5;
      if (i > 16 && i <= 34) r = {r[16:0], sdo};
      else if (sdo !== 1'b0) bad = 1'b1;
      if (i == 16) a15 = alarm;
      sclk = 1'b0;
      #62.5;
      sclk = 1'b1;
    end
    if (sdo !== 1'b0) bad = 1'b1;
    #62.5;
    cs_n = 1'b1;
    sdi  = ~sdi;
    #200;
  endtask : frame

endmodule : host_model

`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the serial frame and alarm block.
// Assumes host_model drives the link; a small core model answers here.
`default_nettype none

module tb_top
  import adc_frame_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              mclk, reset_n, sclk, cs_n, sdi, sdo_out, sdo_oe;
  logic              alarm, conv_start, conv_done, flag_rd, sdo_line;
  logic [2:0]        conv_ch, seen_ch, p1;
  logic [CODE_W-1:0] conv_code, result_code, res;
  logic [7:0]        active_hi, active_lo, tripped_hi, tripped_lo;
  alarm_limits_t [7:0] limits;
  logic [CODE_W-1:0] code_tab [8];
  logic [4:0]        dly;
  logic              seen, bad, a15, exp_al;
  int                err_total, n_compared;

  adc_serial_frame_alarm #(.NCH(8)) u_dut (
    .mclk(mclk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .alarm(alarm),
    .conv_start(conv_start), .conv_ch(conv_ch), .conv_done(conv_done),
    .conv_code(conv_code), .limits(limits), .flag_rd(flag_rd),
    .active_hi(active_hi), .active_lo(active_lo),
    .tripped_hi(tripped_hi), .tripped_lo(tripped_lo),
    .result_code(result_code));

  host_model u_host (
    .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo_line),
    .sdo_oe(sdo_oe), .alarm(alarm));

  // Released line shows the inverse rather than a stale level
  assign sdo_line  = sdo_oe ? sdo_out : ~sdo_out;
  assign conv_done = dly[4];
  assign conv_code = code_tab[conv_ch];

  // ---------------------------------------------------------------
  // Converter core: answers five cycles after each start
  // ---------------------------------------------------------------
  always @(posedge mclk)
  begin
    dly <= #1 {dly[3:0], conv_start};
    if (conv_start === 1'b1)
    begin
      seen    <= 1'b1;
      seen_ch <= conv_ch;
    end
  end

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ---------------------------------------------------------------
  // Compare and report
  // ---------------------------------------------------------------
  task automatic chk_bit(input logic g, input logic e);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_bit

  task automatic chk_code(input logic [CODE_W-1:0] g,
                          input logic [CODE_W-1:0] e);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_code

  task automatic final_report;
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic do_frame(input logic [2:0] ch, input logic al_new);
    logic [CODE_W-1:0] ec;
    ec   = code_tab[p1];
    @(posedge mclk);
    #1;
    seen = 1'b0;
    u_host.frame({13'h0000, ch}, res, bad, a15);
    chk_bit(seen, 1'b1);
    chk_code({15'h0000, seen_ch}, {15'h0000, p1});
    chk_code(res, ec);
    chk_code(result_code, ec);
    chk_bit(bad, 1'b0);
    chk_bit(a15, exp_al);
    chk_bit(alarm, al_new);
    chk_bit(sdo_oe, 1'b0);
    exp_al = al_new;
    p1     = ch;
  endtask : do_frame

  task automatic t_reset;
    chk_bit(alarm, 1'b0);
    chk_bit(sdo_oe, 1'b0);
    chk_bit(conv_start, 1'b0);
    chk_code(result_code, 18'h0_0000);
  endtask : t_reset

  task automatic t_chan;
    logic [2:0] w [7] = '{3'h5, 3'h3, 3'h6, 3'h0, 3'h7, 3'h1, 3'h1};
    int i;
    for (i = 0; i < 7; i++)
      do_frame(w[i], 1'b0);
  endtask : t_chan

  task automatic t_alarm;
    logic [CODE_W-1:0] cv [8] = '{18'h0_03F2, 18'h0_03F3, 18'h0_03DD,
      18'h0_03DC, 18'h0_01EE, 18'h0_01ED, 18'h0_01F9, 18'h0_01FA};
    logic [7:0] eh = 8'h60;
    logic [7:0] el = 8'h06;
    logic th, tl;
    int i;
    th = 1'b0;
    tl = 1'b0;
    for (i = 0; i < 8; i++)
    begin
      code_tab[1] = cv[i];
      th = th | eh[7-i];
      tl = tl | el[7-i];
      do_frame(3'h1, th | tl);
      chk_bit(active_hi[1], eh[7-i]);
      chk_bit(active_lo[1], el[7-i]);
      chk_bit(tripped_hi[1], th);
      chk_bit(tripped_lo[1], tl);
      chk_bit(active_hi[0] | active_lo[0], 1'b0);
    end
  endtask : t_alarm

  task automatic t_clear;
    @(posedge mclk);
    #1;
    flag_rd = 1'b1;
    @(posedge mclk);
    #1;
    flag_rd = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk_bit(tripped_hi[1] | tripped_lo[1], 1'b0);
    chk_bit(alarm, 1'b1);
    code_tab[1] = 18'h0_02EE;
    do_frame(3'h1, 1'b0);
  endtask : t_clear

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    int i;
    reset_n    = 1'b0;
    flag_rd    = 1'b0;
    dly        = 5'h00;
    seen       = 1'b0;
    seen_ch    = 3'h0;
    p1         = 3'h0;
    exp_al     = 1'b0;
    err_total  = 0;
    n_compared = 0;
    for (i = 0; i < 8; i++)
    begin
      limits[i]   = '{18'h3_FFFF, 18'h0_0000, 18'h0_0000, 18'h0_0000};
      code_tab[i] = 18'h2_5A3C ^ {i[2:0], 15'h1234};
    end
    limits[1]   = '{18'h0_03E8, 18'h0_000A, 18'h0_01F4, 18'h0_0005};
    code_tab[1] = 18'h0_02EE;
    repeat (12) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    t_reset();
    t_chan();
    t_alarm();
    t_clear();
    final_report();
  end

  initial
  begin
    #1000000;
    err_total++;
    final_report();
  end

endmodule : tb_top

`default_nettype wire
